// >>> dsf_pkg.sv
// Shared constants and types for the dual converter serial frame control
package dsf_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int RES_W = 12;
  localparam int TAG_W = 4;
  localparam int SLOT_W = 16;
  localparam int FRAME_W = 32;
  localparam int PAIR_W = 2 * RES_W;
  localparam int FIFO_DEPTH = 2;
  localparam logic [TAG_W-1:0] TAG_CONV_A = 4'h0;
  localparam logic [TAG_W-1:0] TAG_CONV_B = 4'h1;

  // ---------------------------------------------------------------
  // Falling edge counts within a frame
  // ---------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] EDGE_GLITCH = 6'h02;
  localparam logic [CNT_W-1:0] EDGE_AWAKE = 6'h0A;
  localparam logic [CNT_W-1:0] EDGE_RESULT = 6'h10;
  localparam logic [CNT_W-1:0] EDGE_DUAL = 6'h20;
  localparam logic [CNT_W-1:0] EDGE_FIRST = 6'h01;
  localparam logic [CNT_W-1:0] EDGE_NONE = 6'h00;

  // ---------------------------------------------------------------
  // Reference selection
  // ---------------------------------------------------------------
  localparam logic REF_SEL_INTERNAL = 1'b0;
  localparam int REF_INTERNAL_MV = 2500;

  // ---------------------------------------------------------------
  // Power modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DSF_PWR_NORMAL = 3'b001,
    DSF_PWR_PARTIAL = 3'b010,
    DSF_PWR_FULL = 3'b100
  } dsf_pwr_e;

endpackage : dsf_pkg

// >>> dsf_pair_fifo.sv
// Two-entry buffer holding result pairs on the system clock
`timescale 1ns/1ps
module dsf_pair_fifo
  import dsf_pkg::*;
#(
  parameter int W = PAIR_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] wr_nxt;
  logic [AW-1:0] rd_r;
  logic [AW-1:0] rd_nxt;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_nxt[i] = mem_r[i];
    end
    if (push)
    begin
      mem_nxt[wr_r] = in_data_i;
    end
    wr_nxt = wr_r;
    if (push)
    begin
      wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : AW'(wr_r + 1'b1);
    end
    rd_nxt = rd_r;
    if (pop)
    begin
      rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : AW'(rd_r + 1'b1);
    end
    cnt_nxt = (AW+1)'(cnt_r + (AW+1)'(push) - (AW+1)'(pop));
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  generate
    for (genvar g = 0; g < DEPTH; g++)
    begin : g_entry
      always_ff @(posedge sys_clk_i)
      begin
        if (!rst_b_i)
          mem_r[g] <= '0;
        else
          mem_r[g] <= mem_nxt[g];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule : dsf_pair_fifo

// >>> dsf_frame_ctrl.sv
// Serial frame control of a dual converter: link, frame decode, power mode
`timescale 1ns/1ps
module dsf_frame_ctrl
  import dsf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic ref_sel_i,
  input wire logic [RES_W-1:0] result_a_i,
  input wire logic [RES_W-1:0] result_b_i,
  input wire logic result_valid_i,
  output logic result_ready_o,
  output logic serial_out_first_converter_o,
  output logic serial_out_first_converter_oe_n_o,
  output logic serial_out_second_converter_o,
  output logic serial_out_second_converter_oe_n_o,
  output logic ref_external_o,
  output logic ref_internal_en_o,
  output dsf_pwr_e pwr_mode_o,
  output logic conv_start_o,
  output logic frame_done_o,
  output logic frame_complete_o,
  output logic frame_dual_o,
  output logic frame_aborted_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic fifo_valid;
  logic fifo_ready;
  logic [PAIR_W-1:0] fifo_data;

  logic cs_s1_r;
  logic cs_s2_r;
  logic ref_s1_r;
  logic ref_s2_r;
  logic ref_ext_r;
  logic ref_ext_nxt;
  logic cons_s1_r;
  logic cons_s2_r;
  logic cons_seen_r;
  logic cons_seen_nxt;
  logic mode_s1_r;
  logic mode_s2_r;
  logic mode_seen_r;
  logic mode_seen_nxt;
  logic [PAIR_W-1:0] shadow_r;
  logic [PAIR_W-1:0] shadow_nxt;
  logic shadow_full_r;
  logic shadow_full_nxt;
  dsf_pwr_e pwr_r;
  dsf_pwr_e pwr_nxt;
  logic start_r;
  logic start_nxt;
  logic done_r;
  logic done_nxt;
  logic complete_r;
  logic complete_nxt;
  logic dual_r;
  logic dual_nxt;
  logic abort_r;
  logic abort_nxt;
  logic cons_evt;
  logic mode_evt;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [PAIR_W-1:0] cap_r;
  logic [PAIR_W-1:0] cap_nxt;
  logic out_a_r;
  logic out_a_nxt;
  logic out_b_r;
  logic out_b_nxt;
  logic cons_tgl_r;
  logic cons_tgl_nxt;
  logic [FRAME_W-1:0] frm_a;
  logic [FRAME_W-1:0] frm_b;
  logic [4:0] bit_idx;

  dsf_pwr_e lmode_r;
  dsf_pwr_e lmode_nxt;
  logic ltgl_r;
  logic ltgl_nxt;
  logic last_cons_r;
  logic last_cons_nxt;
  logic lcomplete_r;
  logic lcomplete_nxt;
  logic ldual_r;
  logic ldual_nxt;
  logic labort_r;
  logic labort_nxt;
  logic started;
  logic [CNT_W-1:0] edges;
  logic line_off;

  // ---------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------
  dsf_pair_fifo #(
    .W(PAIR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(result_valid_i),
    .in_ready_o(result_ready_o),
    .in_data_i({result_a_i, result_b_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_data)
  );

  // ---------------------------------------------------------------
  // System side
  // ---------------------------------------------------------------
  assign cons_evt = cons_s2_r ^ cons_seen_r;
  assign mode_evt = mode_s2_r ^ mode_seen_r;
  // Shadow only reloads between frames so the link sees a steady word
  assign fifo_ready = ~shadow_full_r & cs_s2_r;

  always_comb
  begin
    ref_ext_nxt = (ref_s2_r != REF_SEL_INTERNAL);
    cons_seen_nxt = cons_s2_r;
    mode_seen_nxt = mode_s2_r;
    shadow_nxt = shadow_r;
    shadow_full_nxt = shadow_full_r;
    if (cons_evt)
    begin
      shadow_full_nxt = 1'b0;
    end
    if (fifo_valid & fifo_ready)
    begin
      shadow_nxt = fifo_data;
      shadow_full_nxt = 1'b1;
    end
    start_nxt = cons_evt;
    done_nxt = mode_evt;
    pwr_nxt = pwr_r;
    complete_nxt = complete_r;
    dual_nxt = dual_r;
    abort_nxt = abort_r;
    if (mode_evt)
    begin
      pwr_nxt = lmode_r;
      complete_nxt = lcomplete_r;
      dual_nxt = ldual_r;
      abort_nxt = labort_r;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_ext_r <= 1'b0;
      cons_s1_r <= 1'b0;
      cons_s2_r <= 1'b0;
      cons_seen_r <= 1'b0;
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
      mode_seen_r <= 1'b0;
      shadow_r <= '0;
      shadow_full_r <= 1'b0;
      pwr_r <= DSF_PWR_NORMAL;
      start_r <= 1'b0;
      done_r <= 1'b0;
      complete_r <= 1'b0;
      dual_r <= 1'b0;
      abort_r <= 1'b0;
    end
    else
    begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      ref_s1_r <= ref_sel_i;
      ref_s2_r <= ref_s1_r;
      ref_ext_r <= ref_ext_nxt;
      cons_s1_r <= cons_tgl_r;
      cons_s2_r <= cons_s1_r;
      cons_seen_r <= cons_seen_nxt;
      mode_s1_r <= ltgl_r;
      mode_s2_r <= mode_s1_r;
      mode_seen_r <= mode_seen_nxt;
      shadow_r <= shadow_nxt;
      shadow_full_r <= shadow_full_nxt;
      pwr_r <= pwr_nxt;
      start_r <= start_nxt;
      done_r <= done_nxt;
      complete_r <= complete_nxt;
      dual_r <= dual_nxt;
      abort_r <= abort_nxt;
    end
  end

  assign ref_external_o = ref_ext_r;
  assign ref_internal_en_o = ~ref_ext_r;
  assign pwr_mode_o = pwr_r;
  assign conv_start_o = start_r;
  assign frame_done_o = done_r;
  assign frame_complete_o = complete_r;
  assign frame_dual_o = dual_r;
  assign frame_aborted_o = abort_r;

  // ---------------------------------------------------------------
  // Link side: serial clock falling edges
  // ---------------------------------------------------------------
  // A frame has seen its first edge once the link toggle differs from the
  // value recorded at the previous chip select rise
  assign started = cons_tgl_r ^ last_cons_r;
  assign frm_a = started ? {TAG_CONV_A, cap_r[PAIR_W-1:RES_W], TAG_CONV_B, cap_r[RES_W-1:0]}
                         : {TAG_CONV_A, shadow_r[PAIR_W-1:RES_W], TAG_CONV_B, shadow_r[RES_W-1:0]};
  assign frm_b = started ? {TAG_CONV_B, cap_r[RES_W-1:0], TAG_CONV_A, cap_r[PAIR_W-1:RES_W]}
                         : {TAG_CONV_B, shadow_r[RES_W-1:0], TAG_CONV_A, shadow_r[PAIR_W-1:RES_W]};
  assign bit_idx = 5'(6'h1F - cnt_nxt);

  always_comb
  begin
    cap_nxt = cap_r;
    cons_tgl_nxt = cons_tgl_r;
    if (!started)
    begin
      cnt_nxt = EDGE_FIRST;
      cap_nxt = shadow_r;
      cons_tgl_nxt = ~cons_tgl_r;
    end
    else if (cnt_r == EDGE_DUAL)
    begin
      cnt_nxt = EDGE_DUAL;
    end
    else
    begin
      cnt_nxt = CNT_W'(cnt_r + 1'b1);
    end
    out_a_nxt = 1'b0;
    out_b_nxt = 1'b0;
    if (cnt_nxt != EDGE_DUAL)
    begin
      out_a_nxt = frm_a[bit_idx];
      out_b_nxt = frm_b[bit_idx];
    end
  end

  always_ff @(negedge sclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r <= EDGE_NONE;
      cap_r <= '0;
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
      cons_tgl_r <= 1'b0;
    end
    else if (!cs_n_i)
    begin
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
      cons_tgl_r <= cons_tgl_nxt;
    end
  end

  // Lines float outside a frame, after the 32nd edge, and at once on chip select rise
  assign line_off = cs_n_i | (started & (cnt_r == EDGE_DUAL));
  assign serial_out_first_converter_oe_n_o = line_off;
  assign serial_out_second_converter_oe_n_o = line_off;
  assign serial_out_first_converter_o = started ? out_a_r : TAG_CONV_A[TAG_W-1];
  assign serial_out_second_converter_o = started ? out_b_r : TAG_CONV_B[TAG_W-1];

  // ---------------------------------------------------------------
  // Chip select rise: mode decision
  // ---------------------------------------------------------------
  assign edges = started ? cnt_r : EDGE_NONE;

  always_comb
  begin
    lmode_nxt = lmode_r;
    if (edges >= EDGE_AWAKE)
    begin
      lmode_nxt = DSF_PWR_NORMAL;
    end
    else if (edges >= EDGE_GLITCH)
    begin
      unique case (lmode_r)
        DSF_PWR_NORMAL: lmode_nxt = DSF_PWR_PARTIAL;
        DSF_PWR_PARTIAL: lmode_nxt = DSF_PWR_FULL;
        DSF_PWR_FULL: lmode_nxt = DSF_PWR_FULL;
        default: lmode_nxt = DSF_PWR_NORMAL;
      endcase
    end
    // Fewer than two edges keeps the mode: glitch filter
    lcomplete_nxt = (edges >= EDGE_RESULT);
    ldual_nxt = (edges == EDGE_DUAL);
    labort_nxt = (edges >= EDGE_GLITCH) && (edges < EDGE_RESULT);
    last_cons_nxt = cons_tgl_r;
    ltgl_nxt = ~ltgl_r;
  end

  always_ff @(posedge cs_n_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lmode_r <= DSF_PWR_NORMAL;
      ltgl_r <= 1'b0;
      last_cons_r <= 1'b0;
      lcomplete_r <= 1'b0;
      ldual_r <= 1'b0;
      labort_r <= 1'b0;
    end
    else
    begin
      lmode_r <= lmode_nxt;
      ltgl_r <= ltgl_nxt;
      last_cons_r <= last_cons_nxt;
      lcomplete_r <= lcomplete_nxt;
      ldual_r <= ldual_nxt;
      labort_r <= labort_nxt;
    end
  end

endmodule : dsf_frame_ctrl

// >>> dsf_frame_ctrl_checker.sv
// Assertion checker for the dual converter serial frame control
`timescale 1ns/1ps
module dsf_frame_ctrl_checker
  import dsf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic ref_sel_i,
  input wire logic [RES_W-1:0] result_a_i,
  input wire logic [RES_W-1:0] result_b_i,
  input wire logic result_valid_i,
  input wire logic result_ready_o,
  input wire logic serial_out_first_converter_o,
  input wire logic serial_out_first_converter_oe_n_o,
  input wire logic serial_out_second_converter_o,
  input wire logic serial_out_second_converter_oe_n_o,
  input wire logic ref_external_o,
  input wire logic ref_internal_en_o,
  input wire logic [2:0] pwr_mode_o,
  input wire logic conv_start_o,
  input wire logic frame_done_o,
  input wire logic frame_complete_o,
  input wire logic frame_dual_o,
  input wire logic frame_aborted_o
);
  // ----------------------------------------
  // Frame, mode and reference relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  oe_release_a: assert property (cs_n_i |->
    serial_out_first_converter_oe_n_o && serial_out_second_converter_oe_n_o)
    else $error("line driven with chip select high");
  ref_high_a: assert property (ref_sel_i [*5] |-> ref_external_o)
    else $error("external reference not selected");
  ref_low_a: assert property (!ref_sel_i [*5] |-> !ref_external_o && ref_internal_en_o)
    else $error("internal reference not selected");
  mode_done_a: assert property ($changed(pwr_mode_o) |-> frame_done_o)
    else $error("mode changed outside frame end");
  full_frame_a: assert property (frame_done_o && frame_complete_o |->
    pwr_mode_o == DSF_PWR_NORMAL) else $error("completed frame not normal");
  glitch_keep_a: assert property (frame_done_o && !frame_complete_o &&
    !frame_aborted_o |-> $stable(pwr_mode_o)) else $error("glitch changed mode");
  abort_deep_a: assert property (frame_done_o && frame_aborted_o &&
    $past(pwr_mode_o) != DSF_PWR_NORMAL |-> pwr_mode_o != DSF_PWR_PARTIAL)
    else $error("power-down did not deepen");
  dual_flag_a: assert property (frame_dual_o |-> frame_complete_o && !frame_aborted_o)
    else $error("dual frame flags inconsistent");

  cover property (frame_done_o && frame_dual_o);
  cover property (pwr_mode_o == DSF_PWR_FULL);
  cover property (result_valid_i && !result_ready_o);
endmodule : dsf_frame_ctrl_checker

bind dsf_frame_ctrl dsf_frame_ctrl_checker u_chk (.*);

// >>> dsf_host_model.sv
// Host serial port model: drives chip select and link clock, samples both lines
`timescale 1ns/1ps
module dsf_host_model #(
  parameter int HALF_NS = 24,
  parameter int IDLE_GAP_NS = 150
)(
  output logic sclk_o,
  output logic cs_n_o,
  input wire logic dout_a_i,
  input wire logic oe_a_n_i,
  input wire logic dout_b_i,
  input wire logic oe_b_n_i
);
  logic [31:0] word_a;
  logic [31:0] word_b;
  logic oe_all_low;
  logic oe_low_end;
  logic oe_off_rise;

  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
  end

  // ----------------------------------------
  // One frame of n falling edges; link clock idles high
  // ----------------------------------------
  task automatic run_frame(input int n);
    #7;
    cs_n_o = 1'b0;
    #30;
    word_a = '0;
    word_b = '0;
    oe_all_low = 1'b1;
    repeat (n)
    begin
      #(HALF_NS);
      word_a = {word_a[30:0], dout_a_i};
      word_b = {word_b[30:0], dout_b_i};
      oe_all_low = oe_all_low & !oe_a_n_i & !oe_b_n_i;
      sclk_o = 1'b0;
      #(HALF_NS);
      sclk_o = 1'b1;
    end
    #(HALF_NS);
    oe_low_end = !oe_a_n_i && !oe_b_n_i;
    cs_n_o = 1'b1;
    #1;
    oe_off_rise = oe_a_n_i && oe_b_n_i;
    #(IDLE_GAP_NS);
  endtask : run_frame
endmodule : dsf_host_model

// >>> tb_dual_adc_serial_frame_control.sv
// Self-checking bench for the dual converter serial frame control
`timescale 1ns/1ps
module tb_dual_adc_serial_frame_control
  import dsf_pkg::*;
;
  logic sys_clk_i, rst_b_i, sclk_i, cs_n_i, ref_sel_i, result_valid_i, result_ready_o;
  logic [RES_W-1:0] result_a_i, result_b_i;
  logic serial_out_first_converter_o, serial_out_first_converter_oe_n_o;
  logic serial_out_second_converter_o, serial_out_second_converter_oe_n_o;
  logic ref_external_o, ref_internal_en_o, conv_start_o, frame_done_o;
  logic frame_complete_o, frame_dual_o, frame_aborted_o;
  dsf_pwr_e pwr_mode_o;
  int err_total = 0;
  int n_compared = 0;
  int n_start = 0;

  dsf_frame_ctrl dut (.*);
  dsf_host_model host (
    .sclk_o(sclk_i),
    .cs_n_o(cs_n_i),
    .dout_a_i(serial_out_first_converter_o),
    .oe_a_n_i(serial_out_first_converter_oe_n_o),
    .dout_b_i(serial_out_second_converter_o),
    .oe_b_n_i(serial_out_second_converter_oe_n_o)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
    if (conv_start_o === 1'b1)
      n_start++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic push(input logic [RES_W-1:0] a, output bit ok);
    @(negedge sys_clk_i);
    result_a_i = a;
    result_b_i = ~a;
    result_valid_i = 1'b1;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge sys_clk_i);
      ok = (result_ready_o === 1'b1);
    end
    @(negedge sys_clk_i);
    result_valid_i = 1'b0;
  endtask : push

  task automatic print_verdict;
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_dual;
    bit ok;
    int s0;
    push(12'hA5C, ok);
    repeat (10) @(negedge sys_clk_i);
    s0 = n_start;
    host.run_frame(32);
    check("line a", host.word_a, {TAG_CONV_A, 12'hA5C, TAG_CONV_B, 12'h5A3});
    check("line b", host.word_b, {TAG_CONV_B, 12'h5A3, TAG_CONV_A, 12'hA5C});
    check("driving", host.oe_all_low, 1'h1);
    check("float", host.oe_low_end, 1'h0);
    check("flags", {frame_dual_o, frame_complete_o, frame_aborted_o}, 3'h6);
    check("starts", n_start - s0, 32'h1);
  endtask : t_dual

  task automatic t_single;
    bit ok;
    push(12'h3C7, ok);
    repeat (10) @(negedge sys_clk_i);
    host.run_frame(16);
    check("single", host.word_a[15:0], {TAG_CONV_A, 12'h3C7});
    check("held", host.oe_low_end, 1'h1);
    check("rise", host.oe_off_rise, 1'h1);
    check("flags", {frame_dual_o, frame_complete_o, frame_aborted_o}, 3'h2);
  endtask : t_single

  task automatic t_abort;
    host.run_frame(12);
    check("mode", pwr_mode_o, DSF_PWR_NORMAL);
    check("rise", host.oe_off_rise, 1'h1);
    check("flags", {frame_dual_o, frame_complete_o, frame_aborted_o}, 3'h1);
  endtask : t_abort

  task automatic t_power;
    int n[6] = '{1, 5, 5, 5, 1, 10};
    dsf_pwr_e m[6] = '{DSF_PWR_NORMAL, DSF_PWR_PARTIAL, DSF_PWR_FULL,
      DSF_PWR_FULL, DSF_PWR_FULL, DSF_PWR_NORMAL};
    foreach (n[i])
    begin
      host.run_frame(n[i]);
      check("mode", pwr_mode_o, m[i]);
    end
  endtask : t_power

  task automatic t_buffer;
    bit ok;
    int acc;
    acc = 0;
    for (int i = 0; i < 5; i++)
    begin
      push(12'h100 + 12'(acc), ok);
      acc += int'(ok);
    end
    check("accepted", acc, FIFO_DEPTH + 1);
    for (int i = 0; i < 3; i++)
    begin
      host.run_frame(16);
      check("order", host.word_b[15:0], {TAG_CONV_B, ~(12'h100 + 12'(i))});
    end
    check("ready", result_ready_o, 1'h1);
  endtask : t_buffer

  task automatic t_ref;
    @(negedge sys_clk_i);
    ref_sel_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    check("ext ref", {ref_external_o, ref_internal_en_o}, 2'h2);
    ref_sel_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    check("int ref", {ref_external_o, ref_internal_en_o}, 2'h1);
  endtask : t_ref

  initial
  begin
    rst_b_i = 1'b1;
    ref_sel_i = 1'b0;
    result_a_i = '0;
    result_b_i = '0;
    result_valid_i = 1'b0;
    // Assert reset after time zero so the link side sees a clean falling edge
    #1;
    rst_b_i = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    check("reset mode", pwr_mode_o, DSF_PWR_NORMAL);
    t_dual;
    t_single;
    t_abort;
    t_power;
    t_buffer;
    t_ref;
    print_verdict;
  end

  initial
  begin
    #200000;
    err_total++;
    print_verdict;
  end
endmodule : tb_dual_adc_serial_frame_control
